// *** logic/bmt_map.svh ***
/*
 bmt_map.svh: constants of the baseband marker/trigger block.
 assumes: included by bare name wherever a constant is needed.
*/
`ifndef BMT_MAP_SVH
`define BMT_MAP_SVH

// ---------------------------------------------
// widths and reset values
// ---------------------------------------------
`define BMT_CNT_W 16
`define BMT_PAT_W 64
`define BMT_NUM_MK 3
`define BMT_SYM_DIV_RST 16'h0000
`define BMT_GAIN_FULL 8'hff
`define BMT_POS_MAX 16'hffff

`endif

// *** logic/bmt_pkg.sv ***
/*
 bmt_pkg: types of the baseband marker/trigger block.
 assumes: compiled before every module of the block.
*/
package bmt_pkg;

   typedef enum logic [2:0] {
      TM_AUTO = 3'b000,
      TM_RETRIG = 3'b001,
      TM_ARMED_AUTO = 3'b010,
      TM_ARMED_RETRIG = 3'b011,
      TM_SINGLE = 3'b100
   } bmt_trig_mode_t;

   typedef enum logic [1:0] {
      MK_RESTART = 2'b00,
      MK_PULSE = 2'b01,
      MK_PATTERN = 2'b10,
      MK_RATIO = 2'b11
   } bmt_mk_mode_t;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } bmt_gen_st_t;

endpackage : bmt_pkg

// *** logic/bmt_tick_if.sv ***
/*
 bmt_tick_if: symbol timing shared by the top and its children.
 assumes: one clock; src drives, dst only reads.
*/
`timescale 1ns/1ps
`default_nettype none

interface bmt_tick_if;
   logic sym_en;
   logic restart;
   logic run;
   modport src (output sym_en, output restart, output run);
   modport dst (input sym_en, input restart, input run);
endinterface : bmt_tick_if

`default_nettype wire

// *** logic/bmt_marker.sv ***
/*
 bmt_marker: one marker channel, advanced once per symbol.
 assumes: restart and sym_en coincide on the first symbol.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bmt_map.svh"

module bmt_marker import bmt_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   bmt_tick_if.dst tick,
   input wire logic [1:0] mode,
   input wire logic [15:0] divider,
   input wire logic [63:0] pattern,
   input wire logic [6:0] pat_len,
   input wire logic [15:0] on_len,
   input wire logic [15:0] off_len,
   input wire logic [15:0] delay,
   output logic mark
);
   typedef struct packed {
      logic [15:0] dly;
      logic [16:0] ph;
      logic out;
   } bmt_mk_st_t;

   bmt_mk_st_t q, d;
   logic [16:0] period;
   logic [15:0] half;

   always_comb begin
      half = (divider < 16'h0002) ? 16'h0001 : {1'b0, divider[15:1]};
      case (mode)
         MK_PULSE: period = {half, 1'b0};
         MK_PATTERN: period = (pat_len == 7'h00) ? 17'h00001 : {10'h000, pat_len};
         MK_RATIO: period = {1'b0, on_len} + {1'b0, off_len};
         default: period = 17'h1ffff;
      endcase
   end

   always_comb begin
      d = q;
      if (!tick.run) begin
         d.out = 1'b0;
      end else if (tick.sym_en) begin
         if (tick.restart) begin
            d.dly = delay;
            d.ph = 17'h00000;
         end else if (q.dly != 16'h0000) begin
            d.dly = q.dly - 16'h0001;
            d.ph = 17'h00000;
         end else if (q.ph + 17'h00001 >= period) begin
            d.ph = (mode == MK_RESTART) ? q.ph : 17'h00000;
         end else begin
            d.ph = q.ph + 17'h00001;
         end
         if (d.dly != 16'h0000) begin
            d.out = 1'b0;
         end else begin
            case (mode)
               MK_RESTART: d.out = (d.ph == 17'h00000);
               MK_PULSE: d.out = (d.ph < {1'b0, half});
               MK_PATTERN: d.out = pattern[d.ph[5:0]];
               MK_RATIO: d.out = (d.ph < {1'b0, on_len});
               default: d.out = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign mark = q.out;
endmodule : bmt_marker

`default_nettype wire

// *** logic/bmt_ramp.sv ***
/*
 bmt_ramp: burst-gate envelope ramp and level attenuation.
 assumes: gate and level inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bmt_map.svh"

module bmt_ramp import bmt_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   bmt_tick_if.dst tick,
   input wire logic gate,
   input wire logic lev_att,
   input wire logic ramp_en,
   input wire logic att_en,
   input wire logic [7:0] att_level,
   input wire logic [3:0] ramp_shift,
   input wire logic ramp_fn,
   input wire logic [15:0] rise_dly,
   input wire logic [15:0] fall_dly,
   output logic [7:0] gain,
   output logic out_en
);
   typedef struct packed {
      logic seen;
      logic pend;
      logic [15:0] cnt;
      logic eff;
      logic att;
      logic [15:0] pos;
   } bmt_rp_st_t;

   bmt_rp_st_t q, d;
   logic [16:0] step;
   logic [16:0] sum;
   logic [7:0] shp;

   // smooth edge: two parabolas meeting at mid level
   function automatic logic [7:0] shape(input logic fn, input logic [7:0] x);
      logic [15:0] sq;
      logic [7:0] y;
      sq = 16'h0000;
      if (!fn) begin
         return x;
      end
      y = x[7] ? ~x : x;
      sq = y * y;
      return x[7] ? ~sq[14:7] : sq[14:7];
   endfunction : shape

   always_comb begin
      d = q;
      step = 17'h10000 >> ramp_shift;
      sum = 17'h00000;
      if (!tick.run) begin
         d = '0;
      end else if (tick.sym_en) begin
         d.att = lev_att & att_en;
         if (gate != q.seen) begin
            d.seen = gate;
            d.pend = 1'b1;
            d.cnt = gate ? rise_dly : fall_dly;
         end else if (q.pend) begin
            if (q.cnt == 16'h0000) begin
               d.pend = 1'b0;
               d.eff = q.seen;
            end else begin
               d.cnt = q.cnt - 16'h0001;
            end
         end
         if (!ramp_en) begin
            d.pos = q.eff ? `BMT_POS_MAX : 16'h0000;
         end else if (q.eff) begin
            sum = {1'b0, q.pos} + step;
            d.pos = sum[16] ? `BMT_POS_MAX : sum[15:0];
         end else begin
            sum = {1'b0, q.pos} - step;
            d.pos = sum[16] ? 16'h0000 : sum[15:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign shp = shape(ramp_fn, q.pos[15:8]);
   assign gain = (q.att && shp > att_level) ? att_level : shp;
   assign out_en = q.eff | (q.pos != 16'h0000);
endmodule : bmt_ramp

`default_nettype wire

// *** logic/bmt_top.sv ***
/*
 bmt_top: baseband marker and trigger generator with envelope control.
 assumes: command pulses and configuration come from logic on CLK_IN;
 EXT_TRIG_IN and SYNC_IN are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bmt_map.svh"

module bmt_top import bmt_pkg::*; (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   // symbol clock divider
   input wire logic [15:0] SYM_DIV_IN,
   // generation and trigger control
   input wire logic MOD_EN_IN,
   input wire logic [2:0] TRIG_MODE_IN,
   input wire logic TRIG_SRC_EXT_IN,
   input wire logic SLAVE_IN,
   input wire logic EXT_POL_FALL_IN,
   input wire logic EXEC_TRIG_IN,
   input wire logic ARM_IN,
   input wire logic [31:0] SINGLE_LEN_IN,
   // trigger pins
   input wire logic EXT_TRIG_IN,
   input wire logic SYNC_IN,
   // marker configuration, three channels packed
   input wire logic [5:0] MK_MODE_IN,
   input wire logic [2:0] MK_ROUTE_TM_IN,
   input wire logic [47:0] MK_DIV_IN,
   input wire logic [191:0] MK_PAT_IN,
   input wire logic [20:0] MK_PAT_LEN_IN,
   input wire logic [47:0] MK_ON_IN,
   input wire logic [47:0] MK_OFF_IN,
   input wire logic [47:0] MK_DLY_IN,
   // control signals and ramp settings
   input wire logic BURST_GATE_IN,
   input wire logic LEV_ATT_IN,
   input wire logic RAMP_EN_IN,
   input wire logic ATT_EN_IN,
   input wire logic [7:0] ATT_LEVEL_IN,
   input wire logic [3:0] RAMP_SHIFT_IN,
   input wire logic RAMP_FN_IN,
   input wire logic [15:0] RISE_DLY_IN,
   input wire logic [15:0] FALL_DLY_IN,
   // outputs
   output logic RUNNING_OUT,
   output logic TRIG_MARK_OUT,
   output logic [2:0] MK_USER_OUT,
   output logic [2:0] MK_TM_OUT,
   output logic [7:0] GAIN_OUT,
   output logic OUT_EN_OUT
);

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      bmt_gen_st_t st;
      logic [15:0] div_cnt;
      logic sym_en;
      logic restart;
      logic run;
      logic pend;
      logic [31:0] dur;
      logic [1:0] ext_s;
      logic ext_last;
      logic [1:0] sync_s;
      logic sync_last;
      logic trig_mark;
      logic [2:0] mk_user;
      logic [2:0] mk_tm;
      logic [7:0] gain;
      logic out_en;
   } bmt_top_st_t;

   bmt_top_st_t q, d;

   bmt_tick_if tick ();

   logic [2:0] mk_raw;
   logic [7:0] rp_gain;
   logic rp_out_en;
   logic ext_lvl;
   logic ext_edge;
   logic sync_edge;
   logic trig;
   logic sym_now;
   bmt_trig_mode_t mode;

   // mode that accepts a trigger while already running
   function automatic logic restarts(input bmt_trig_mode_t m);
      return (m == TM_RETRIG) || (m == TM_ARMED_RETRIG) || (m == TM_SINGLE);
   endfunction : restarts

   // mode that honours an arm request
   function automatic logic armable(input bmt_trig_mode_t m);
      return (m == TM_ARMED_AUTO) || (m == TM_ARMED_RETRIG);
   endfunction : armable

   // ---------------------------------------------
   // interface drive
   // ---------------------------------------------
   assign tick.sym_en = q.sym_en;
   assign tick.restart = q.restart;
   assign tick.run = q.run;

   // ---------------------------------------------
   // trigger event decode
   // ---------------------------------------------
   always_comb begin
      mode = bmt_trig_mode_t'(TRIG_MODE_IN);
      // one polarity serves every baseband on this pin
      ext_lvl = q.ext_s[1] ^ EXT_POL_FALL_IN;
      ext_edge = ext_lvl & ~(q.ext_last ^ EXT_POL_FALL_IN);
      sync_edge = q.sync_s[1] & ~q.sync_last;
      if (SLAVE_IN) begin
         // slave ignores the source selection entirely
         trig = sync_edge;
      end else begin
         trig = EXEC_TRIG_IN | (TRIG_SRC_EXT_IN & ext_edge);
      end
   end

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      d = q;
      // pin synchronisers; first stage feeds only the second
      d.ext_s = {q.ext_s[0], EXT_TRIG_IN};
      d.ext_last = q.ext_s[1];
      d.sync_s = {q.sync_s[0], SYNC_IN};
      d.sync_last = q.sync_s[1];

      // symbol rate enable from the system clock
      sym_now = (q.div_cnt == 16'h0000);
      d.div_cnt = sym_now ? SYM_DIV_IN : q.div_cnt - 16'h0001;
      d.sym_en = sym_now;
      d.restart = 1'b0;
      d.trig_mark = trig;

      case (q.st)
         ST_OFF: begin
            d.run = 1'b0;
            d.pend = 1'b0;
            if (MOD_EN_IN) begin
               if (mode == TM_AUTO && !SLAVE_IN) begin
                  d.st = ST_RUN;
                  d.pend = 1'b1;
               end else begin
                  d.st = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            d.run = 1'b0;
            if (trig) begin
               d.st = ST_RUN;
               d.pend = 1'b1;
            end
         end
         ST_RUN: begin
            if (ARM_IN && armable(mode)) begin
               d.st = ST_WAIT;
               d.run = 1'b0;
               d.pend = 1'b0;
            end else if (trig && restarts(mode)) begin
               d.pend = 1'b1;
            end
         end
         default: begin
            d.st = ST_OFF;
            d.run = 1'b0;
            d.pend = 1'b0;
         end
      endcase

      // starts land on a symbol boundary so markers line up
      if (d.st == ST_RUN && sym_now) begin
         if (d.pend) begin
            d.pend = 1'b0;
            d.run = 1'b1;
            d.restart = 1'b1;
            d.dur = 32'h0000_0001;
         end else if (q.run) begin
            if (mode == TM_SINGLE && q.dur >= SINGLE_LEN_IN) begin
               d.run = 1'b0;
               d.st = ST_WAIT;
            end else begin
               d.dur = q.dur + 32'h0000_0001;
            end
         end
      end

      if (!MOD_EN_IN) begin
         d.st = ST_OFF;
         d.run = 1'b0;
         d.pend = 1'b0;
      end

      // marker routing, one connector per channel
      for (int i = 0; i < `BMT_NUM_MK; i++) begin
         d.mk_user[i] = mk_raw[i] & ~MK_ROUTE_TM_IN[i];
         d.mk_tm[i] = mk_raw[i] & MK_ROUTE_TM_IN[i];
      end
      d.gain = q.run ? rp_gain : 8'h00;
      d.out_en = q.run & rp_out_en;
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------
   // marker channels
   // ---------------------------------------------
   generate
      for (genvar g = 0; g < `BMT_NUM_MK; g++) begin : g_mk
         bmt_marker u_mk (
            .clk(CLK_IN),
            .rst_n(RESETN_IN),
            .tick(tick),
            .mode(MK_MODE_IN[2*g +: 2]),
            .divider(MK_DIV_IN[16*g +: 16]),
            .pattern(MK_PAT_IN[64*g +: 64]),
            .pat_len(MK_PAT_LEN_IN[7*g +: 7]),
            .on_len(MK_ON_IN[16*g +: 16]),
            .off_len(MK_OFF_IN[16*g +: 16]),
            .delay(MK_DLY_IN[16*g +: 16]),
            .mark(mk_raw[g])
         );
      end
   endgenerate

   // ---------------------------------------------
   // envelope
   // ---------------------------------------------
   bmt_ramp u_ramp (
      .clk(CLK_IN),
      .rst_n(RESETN_IN),
      .tick(tick),
      .gate(BURST_GATE_IN),
      .lev_att(LEV_ATT_IN),
      .ramp_en(RAMP_EN_IN),
      .att_en(ATT_EN_IN),
      .att_level(ATT_LEVEL_IN),
      .ramp_shift(RAMP_SHIFT_IN),
      .ramp_fn(RAMP_FN_IN),
      .rise_dly(RISE_DLY_IN),
      .fall_dly(FALL_DLY_IN),
      .gain(rp_gain),
      .out_en(rp_out_en)
   );

   // ---------------------------------------------
   // outputs, all registered
   // ---------------------------------------------
   assign RUNNING_OUT = q.run;
   assign TRIG_MARK_OUT = q.trig_mark;
   assign MK_USER_OUT = q.mk_user;
   assign MK_TM_OUT = q.mk_tm;
   assign GAIN_OUT = q.gain;
   assign OUT_EN_OUT = q.out_en;

endmodule : bmt_top

`default_nettype wire

// *** tb/bmt_far_model.sv ***
/*
 bmt_far_model: test equipment on the trigger pins of the marker block.
 assumes: bench calls ext_pulse or sync_pulse at a falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module bmt_far_model (
   // clock and shared polarity
   input wire logic clk_in,
   input wire logic fall_pol_in,
   // pins into the block
   output logic ext_trig_out,
   output logic sync_out
);
   logic ext_act = 1'b0;

   initial sync_out = 1'b0;
   // idle level is the inverse of the active edge
   assign ext_trig_out = fall_pol_in ^ ext_act;

   // held four clocks so the two-flop synchroniser cannot miss it
   task automatic ext_pulse();
      @(negedge clk_in);
      ext_act = 1'b1;
      repeat (4) @(negedge clk_in);
      ext_act = 1'b0;
   endtask : ext_pulse

   task automatic sync_pulse();
      @(negedge clk_in);
      sync_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sync_out = 1'b0;
   endtask : sync_pulse
endmodule : bmt_far_model

`default_nettype wire

// *** tb/bmt_top_assertions.sv ***
/*
 bmt_top_assertions: port-level checks of the marker/trigger block.
 assumes: bound to bmt_top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bmt_top_assertions import bmt_pkg::*; (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic [15:0] SYM_DIV_IN,
   input wire logic MOD_EN_IN,
   input wire logic [2:0] TRIG_MODE_IN,
   input wire logic SLAVE_IN,
   input wire logic EXEC_TRIG_IN,
   input wire logic ARM_IN,
   input wire logic SYNC_IN,
   input wire logic [5:0] MK_MODE_IN,
   input wire logic [2:0] MK_ROUTE_TM_IN,
   input wire logic [47:0] MK_DLY_IN,
   input wire logic BURST_GATE_IN,
   input wire logic LEV_ATT_IN,
   input wire logic RAMP_EN_IN,
   input wire logic ATT_EN_IN,
   input wire logic [7:0] ATT_LEVEL_IN,
   input wire logic [15:0] FALL_DLY_IN,
   input wire logic RUNNING_OUT,
   input wire logic TRIG_MARK_OUT,
   input wire logic [2:0] MK_USER_OUT,
   input wire logic [2:0] MK_TM_OUT,
   input wire logic [7:0] GAIN_OUT,
   input wire logic OUT_EN_OUT
);
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   a_auto_start: assert property ($rose(MOD_EN_IN) && TRIG_MODE_IN == TM_AUTO && !SLAVE_IN
      && SYM_DIV_IN == 16'h0 |=> RUNNING_OUT) else $error("auto start late");
   a_mod_stop: assert property (!MOD_EN_IN [*2] |-> !RUNNING_OUT)
      else $error("running without modulation");
   a_trig_mark: assert property (EXEC_TRIG_IN && MOD_EN_IN && !SLAVE_IN
      && TRIG_MODE_IN == TM_RETRIG |=> TRIG_MARK_OUT) else $error("trigger not marked");
   a_arm_stop: assert property (ARM_IN && RUNNING_OUT && MOD_EN_IN
      && (TRIG_MODE_IN == TM_ARMED_AUTO || TRIG_MODE_IN == TM_ARMED_RETRIG)
      |=> !RUNNING_OUT) else $error("arm did not stop");
   a_slave_wait: assert property ((SLAVE_IN && !SYNC_IN && !RUNNING_OUT
      && SYM_DIV_IN == 16'h0) [*5] |=> !RUNNING_OUT) else $error("slave ran without sync");
   a_restart_pulse: assert property ($rose(RUNNING_OUT) && MK_MODE_IN[1:0] == MK_RESTART
      && MK_DLY_IN[15:0] == 16'h0 && !MK_ROUTE_TM_IN[0] && SYM_DIV_IN == 16'h0
      |-> ##2 MK_USER_OUT[0] ##1 !MK_USER_OUT[0]) else $error("restart marker wrong");
   a_mk_off: assert property (!RUNNING_OUT [*3] |-> MK_USER_OUT == 3'h0
      && MK_TM_OUT == 3'h0 && GAIN_OUT == 8'h00) else $error("marker active while stopped");
   a_route_excl: assert property ((MK_USER_OUT & MK_TM_OUT) == 3'h0)
      else $error("marker on both connectors");
   a_att_ceiling: assert property ((ATT_EN_IN && LEV_ATT_IN && !RAMP_EN_IN) [*6]
      |-> GAIN_OUT <= ATT_LEVEL_IN) else $error("attenuation not applied");
   a_gate_off: assert property ((!BURST_GATE_IN && !RAMP_EN_IN && FALL_DLY_IN == 16'h0) [*6]
      |-> !OUT_EN_OUT && GAIN_OUT == 8'h00) else $error("output outside gate");

   c_start: cover property ($rose(RUNNING_OUT));
   c_mark: cover property (TRIG_MARK_OUT);
   c_arm: cover property (ARM_IN && RUNNING_OUT);
endmodule : bmt_top_assertions

`default_nettype wire

// *** tb/test_bmt_top.sv ***
/*
 test_bmt_top: directed bench of the marker/trigger block.
 assumes: SYM_DIV 0, so every clock is one symbol, except in the single-mode run.
*/
`timescale 1ns/1ps
`default_nettype none

module test_bmt_top import bmt_pkg::*;;
   logic CLK_IN, RESETN_IN, MOD_EN_IN, TRIG_SRC_EXT_IN, SLAVE_IN, EXT_POL_FALL_IN, EXEC_TRIG_IN;
   logic ARM_IN, BURST_GATE_IN, LEV_ATT_IN, RAMP_EN_IN, ATT_EN_IN, RAMP_FN_IN, EXT_TRIG_IN, SYNC_IN;
   logic RUNNING_OUT, TRIG_MARK_OUT, OUT_EN_OUT, mid;
   logic [15:0] SYM_DIV_IN, RISE_DLY_IN, FALL_DLY_IN;
   logic [2:0] TRIG_MODE_IN, MK_ROUTE_TM_IN, MK_USER_OUT, MK_TM_OUT;
   logic [31:0] SINGLE_LEN_IN;
   logic [5:0] MK_MODE_IN;
   logic [47:0] MK_DIV_IN, MK_ON_IN, MK_OFF_IN, MK_DLY_IN;
   logic [191:0] MK_PAT_IN;
   logic [20:0] MK_PAT_LEN_IN;
   logic [7:0] ATT_LEVEL_IN, GAIN_OUT;
   logic [3:0] RAMP_SHIFT_IN;
   int error_cnt = 0, checked = 0, cyc = 0, n;

   bmt_top dut (.*);
   bmt_far_model far (.clk_in(CLK_IN), .fall_pol_in(EXT_POL_FALL_IN),
      .ext_trig_out(EXT_TRIG_IN), .sync_out(SYNC_IN));

   initial begin
      CLK_IN = 1'b0;
      forever #2 CLK_IN = ~CLK_IN;
   end
   // whole run is well under a thousand symbols
   always @(posedge CLK_IN) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic step(input int k);
      repeat (k) @(negedge CLK_IN);
   endtask : step
   task automatic pulse_exec();
      EXEC_TRIG_IN = 1'b1;
      step(1);
      EXEC_TRIG_IN = 1'b0;
   endtask : pulse_exec
   task automatic wait_run();
      for (int i = 0; i < 24 && RUNNING_OUT !== 1'b1; i++) step(1);
      chk("running", 8'(RUNNING_OUT), 8'h01);
   endtask : wait_run
   // symbol k counted from the first generated symbol
   function automatic logic exp_mk(input int i, input int k);
      int d, h, m, on, per;
      d = k - int'(MK_DLY_IN[16*i +: 16]);
      h = int'(MK_DIV_IN[16*i +: 16]) / 2;
      m = int'(MK_PAT_LEN_IN[7*i +: 7]);
      on = int'(MK_ON_IN[16*i +: 16]);
      per = on + int'(MK_OFF_IN[16*i +: 16]);
      if (d < 0) return 1'b0;
      case (MK_MODE_IN[2*i +: 2])
         MK_RESTART: return d == 0;
         MK_PULSE: return ((d / (h < 1 ? 1 : h)) % 2) == 0;
         MK_PATTERN: return MK_PAT_IN[64*i + (d % (m < 1 ? 1 : m))];
         default: return (d % per) < on;
      endcase
   endfunction : exp_mk
   task automatic trig_cap(input int cnt);
      pulse_exec();
      chk("trig_mark", 8'(TRIG_MARK_OUT), 8'h01);
      step(1);
      for (int k = 0; k < cnt; k++) begin
         step(1);
         for (int i = 0; i < 3; i++) begin
            chk("mk_user", 8'(MK_USER_OUT[i]), 8'(exp_mk(i, k) & !MK_ROUTE_TM_IN[i]));
            chk("mk_tm", 8'(MK_TM_OUT[i]), 8'(exp_mk(i, k) & MK_ROUTE_TM_IN[i]));
         end
      end
   endtask : trig_cap

   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      {RESETN_IN, MOD_EN_IN, TRIG_SRC_EXT_IN, SLAVE_IN, EXT_POL_FALL_IN, EXEC_TRIG_IN} = 6'h0;
      {ARM_IN, BURST_GATE_IN, LEV_ATT_IN, RAMP_EN_IN, ATT_EN_IN, RAMP_FN_IN} = 6'h0;
      {SYM_DIV_IN, RISE_DLY_IN, FALL_DLY_IN, SINGLE_LEN_IN} = 80'h0;
      {TRIG_MODE_IN, MK_ROUTE_TM_IN, MK_MODE_IN, MK_PAT_LEN_IN} = 33'h0;
      {MK_DIV_IN, MK_ON_IN, MK_OFF_IN, MK_DLY_IN, MK_PAT_IN} = 384'h0;
      {ATT_LEVEL_IN, RAMP_SHIFT_IN} = 12'h0;
      step(3);
      RESETN_IN = 1'b1;
      step(2);
      chk("auto_early", 8'(RUNNING_OUT), 8'h00);
      MOD_EN_IN = 1'b1;
      step(1);
      chk("auto_run", 8'(RUNNING_OUT), 8'h01);
      {ATT_EN_IN, ATT_LEVEL_IN, BURST_GATE_IN, LEV_ATT_IN} = {1'b1, 8'h40, 2'b11};
      step(8);
      chk("att_gain", GAIN_OUT, 8'h40);
      LEV_ATT_IN = 1'b0;
      step(8);
      chk("full_gain", GAIN_OUT, 8'hff);
      BURST_GATE_IN = 1'b0;
      step(8);
      chk("gate_off", {GAIN_OUT[6:0], OUT_EN_OUT}, 8'h00);
      {RISE_DLY_IN, RAMP_EN_IN, RAMP_FN_IN, RAMP_SHIFT_IN, BURST_GATE_IN} = {16'h0014, 7'h65};
      step(6);
      chk("rise_dly", GAIN_OUT, 8'h00);
      mid = 1'b0;
      for (int i = 0; i < 40; i++) begin
         step(1);
         mid |= (GAIN_OUT !== 8'h00 && GAIN_OUT !== 8'hff);
      end
      chk("ramp_mid", 8'(mid), 8'h01);
      chk("ramp_end", GAIN_OUT, 8'hff);
      MOD_EN_IN = 1'b0;
      step(4);
      chk("stopped", {GAIN_OUT[4:0], MK_USER_OUT}, 8'h00);
      TRIG_MODE_IN = TM_RETRIG;
      MOD_EN_IN = 1'b1;
      step(6);
      chk("wait_trig", 8'(RUNNING_OUT), 8'h00);
      // restart, pulse divided by 4, five-bit pattern
      {MK_MODE_IN, MK_ROUTE_TM_IN, MK_DIV_IN} = {MK_PATTERN, MK_PULSE, MK_RESTART, 3'h2, 48'h40000};
      {MK_PAT_IN, MK_PAT_LEN_IN} = {64'hd, 128'h0, 21'h14000};
      trig_cap(10);
      trig_cap(10);
      // delayed pulse, 64-bit pattern, ratio 1:2
      {MK_MODE_IN, MK_ROUTE_TM_IN, MK_DIV_IN} = {MK_RATIO, MK_PATTERN, MK_PULSE, 3'h5, 48'h1};
      {MK_PAT_IN, MK_PAT_LEN_IN} = {64'h0, 64'h8000_0000_0000_0009, 64'h0, 21'h2000};
      {MK_ON_IN, MK_OFF_IN, MK_DLY_IN} = {48'h1_0000_0000, 48'h2_0000_0000, 48'h3_0000_0002};
      trig_cap(70);
      TRIG_SRC_EXT_IN = 1'b1;
      TRIG_MODE_IN = TM_ARMED_RETRIG;
      for (int p = 0; p < 2; p++) begin
         EXT_POL_FALL_IN = p[0];
         step(4);
         ARM_IN = 1'b1;
         step(1);
         ARM_IN = 1'b0;
         step(1);
         chk("arm_stop", 8'(RUNNING_OUT), 8'h00);
         step(6);
         chk("arm_hold", 8'(RUNNING_OUT), 8'h00);
         far.ext_pulse();
         wait_run();
      end
      {SLAVE_IN, TRIG_MODE_IN, MOD_EN_IN} = {1'b1, TM_AUTO, 1'b0};
      step(2);
      MOD_EN_IN = 1'b1;
      pulse_exec();
      step(8);
      chk("slave_wait", 8'(RUNNING_OUT), 8'h00);
      far.sync_pulse();
      wait_run();
      // two clocks a symbol here, so five symbols last ten clocks
      {SLAVE_IN, TRIG_MODE_IN, SINGLE_LEN_IN, MOD_EN_IN, SYM_DIV_IN} = {1'b0, TM_SINGLE, 32'h5, 1'b0, 16'h1};
      step(2);
      MOD_EN_IN = 1'b1;
      step(2);
      pulse_exec();
      wait_run();
      for (n = 0; RUNNING_OUT === 1'b1 && n < 40; n++) step(1);
      chk("single_len", 8'(n), 8'h0a);
      wrap_up();
   end
endmodule : test_bmt_top

bind bmt_top bmt_top_assertions chk_i (.*);

`default_nettype wire
